// [verilog/fds_pkg.sv]
// Purpose: shared constants and types of the flash driver supervision block
// Assumes: 32-bit classic wishbone register access, word aligned
// Notes: analog comparator decisions arrive as digital levels
package fds_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TORCH = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VOLT = 2'h3;
  localparam logic [3:0] INDICATOR_LEVEL_OFF = 4'h0;
  localparam logic [1:0] TJ_HOT = 2'h3;
  localparam logic [1:0] TJ_COOL = 2'h0;
  // control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_VME = 2;
  localparam int CTRL_THERMISTOR_SENSE_ENABLE = 3;
  localparam int CTRL_PGTYPE = 4;
  localparam int CTRL_HC = 5;
  localparam int CTRL_LED_LSB = 6;
  localparam int CTRL_INDICATOR_LEVEL_LSB = 9;
  // status register field positions
  localparam int ST_PG = 0;
  localparam int ST_WARN = 1;
  localparam int ST_HOT = 2;
  localparam int ST_TJ_LSB = 3;
  localparam int ST_SHDN = 5;
  localparam int ST_TSD = 6;
  localparam int ST_UVLO = 7;
  localparam logic [2:0] LED_RESET = 3'h7;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] mode;
    logic vme;
    logic thermistor_sense_enable;
    logic pg_type;
    logic hc;
    logic [2:0] leds;
    logic [3:0] indicator_level;
  } fds_ctrl_s;

  typedef struct packed {
    logic in_window;
    logic recycling;
    logic ts_warn;
    logic ts_hot;
    logic [1:0] tj_level;
    logic tj_over;
    logic tj_cool;
    logic vbat_ok;
  } fds_sense_s;

  typedef struct packed {
    logic [2:0] led_sink_en;
    logic flash_current;
    logic ilim_reduced;
    logic safety_timer_en;
    logic switch_en;
    logic rectifier_en;
    logic precharge_bias;
    logic load_disconnect;
    logic discharge;
    logic balance_en;
    logic ts_bias_en;
  } fds_power_s;

  typedef struct packed {
    logic [1:0] hwd_sync;
    logic [1:0] torch_sync;
    logic [1:0] blank_sync;
    fds_ctrl_s ctrl;
    logic pg;
    logic warn;
    logic overheat;
    logic [1:0] tj_sticky;
    logic [1:0] tj_live;
    logic tsd;
    logic shdn;
    logic uvlo;
    logic pg_out;
    logic pg_oe;
    fds_power_s pwr;
    logic ack;
    logic [31:0] dat;
  } fds_state_s;
endpackage

// [verilog/fds_supervisor.sv]
// Purpose: supervisory control of a boost LED flash driver
// Assumes: inputs synchronous to clk_i, comparator levels already settled
// Notes: pins hw disable, torch and blank go through two-flop synchronisers
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - power-good monitor active only in voltage regulation
// - shutdown pin: pulled low or open drain
// - push-pull follows flag; open-drain low when good
// - power good only inside output window
// - power good low when regulation suspended
// - power good low while recycling energy
// - thermistor sensing by mode, thermistor_sense_enable, shutdown
// - warn flag below warning threshold, runs on
// - LED overheat latches, clears mode, sets level
// - report junction level except full shutdown
// - hardware disable resets registers, enters shutdown
// - hardware torch never runs safety timer
// - torch pin gated by mode and indicator
// - blank drops flash to torch current unless hc is set
// - high current: blank lowers input limit
// - undervoltage blocks both power switches
// - shutdown only with vme and torch off
// - direct-drive shutdown: off, disconnect, discharge
// - high-current shutdown: bias output, balance on
// - overtemperature stops stage, sticky level bits
// - cool-down resumes voltage mode only
module fds_supervisor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hardware_disable_n_i,
  input wire logic torch_hw_enable_i,
  input wire logic flash_blank_input_i,
  input wire fds_pkg::fds_sense_s sense_i,
  output logic power_good_pin_o,
  output logic power_good_pin_oe_o,
  output fds_pkg::fds_power_s power_o,
  output logic shutdown_o
);
  fds_pkg::fds_state_s st_q;
  fds_pkg::fds_state_s st_d;

  function automatic logic [31:0] ctrl_word(input fds_pkg::fds_ctrl_s c);
    logic [31:0] w;
    w = fds_pkg::DATA_ZERO;
    w[fds_pkg::CTRL_MODE_LSB +: 2] = c.mode;
    w[fds_pkg::CTRL_VME] = c.vme;
    w[fds_pkg::CTRL_THERMISTOR_SENSE_ENABLE] = c.thermistor_sense_enable;
    w[fds_pkg::CTRL_PGTYPE] = c.pg_type;
    w[fds_pkg::CTRL_HC] = c.hc;
    w[fds_pkg::CTRL_LED_LSB +: 3] = c.leds;
    w[fds_pkg::CTRL_INDICATOR_LEVEL_LSB +: 4] = c.indicator_level;
    return w;
  endfunction

  function automatic fds_pkg::fds_ctrl_s ctrl_reset();
    fds_pkg::fds_ctrl_s c;
    c = '0;
    c.leds = fds_pkg::LED_RESET;
    return c;
  endfunction

  logic hwd_n;
  logic torch_pin;
  logic blank;
  logic vm_active;
  logic cm_mode;
  logic torch_ok;
  logic shdn;
  logic regulating;
  logic ts_active;
  logic tsd_next;
  logic led_hot;
  logic req;
  logic wr;
  logic rd_status;
  logic [31:0] wmask;
  logic [31:0] cword;
  logic [31:0] sword;
  fds_pkg::fds_ctrl_s c;

  always_comb begin
    st_d = st_q;
    c = st_q.ctrl;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    cword = fds_pkg::DATA_ZERO;
    sword = fds_pkg::DATA_ZERO;

    // synchronisers: only the second stage feeds any decision
    st_d.hwd_sync = {st_q.hwd_sync[0], hardware_disable_n_i};
    st_d.torch_sync = {st_q.torch_sync[0], torch_hw_enable_i};
    st_d.blank_sync = {st_q.blank_sync[0], flash_blank_input_i};
    hwd_n = st_q.hwd_sync[1];
    torch_pin = st_q.torch_sync[1];
    blank = st_q.blank_sync[1];

    vm_active = (c.mode == fds_pkg::MODE_VOLT) || c.vme;
    cm_mode = (c.mode == fds_pkg::MODE_TORCH) || (c.mode == fds_pkg::MODE_FLASH);
    torch_ok = torch_pin && ((c.mode == fds_pkg::MODE_OFF) || vm_active)
               && (c.indicator_level == fds_pkg::INDICATOR_LEVEL_OFF);
    // mode 00 alone is not shutdown while vme or the torch pin hold it up
    shdn = (c.mode == fds_pkg::MODE_OFF) && !c.vme && !torch_pin;
    regulating = cm_mode || torch_ok;
    if (regulating) begin
      ts_active = 1'b1;
    end else if (c.mode == fds_pkg::MODE_VOLT) begin
      ts_active = c.thermistor_sense_enable;
    end else begin
      ts_active = 1'b0;
    end
    if (shdn) begin
      ts_active = 1'b0;
    end

    // thermal shutdown latches at the hot trip and releases below the cool trip
    if (sense_i.tj_over) begin
      tsd_next = 1'b1;
    end else if (sense_i.tj_cool) begin
      tsd_next = 1'b0;
    end else begin
      tsd_next = st_q.tsd;
    end
    st_d.tsd = tsd_next;
    led_hot = regulating && ts_active && sense_i.ts_hot;

    // bus: one-cycle ack, never back to back on the same request
    req = wb_cyc_i && wb_stb_i && !st_q.ack;
    wr = req && wb_we_i;
    rd_status = req && !wb_we_i && (wb_adr_i == fds_pkg::ADDR_STATUS);
    st_d.ack = req;

    cword = ctrl_word(c);
    sword[fds_pkg::ST_PG] = st_q.pg;
    sword[fds_pkg::ST_WARN] = st_q.warn;
    sword[fds_pkg::ST_HOT] = st_q.overheat;
    sword[fds_pkg::ST_TJ_LSB +: 2] = st_q.tj_live | st_q.tj_sticky;
    sword[fds_pkg::ST_SHDN] = st_q.shdn;
    sword[fds_pkg::ST_TSD] = st_q.tsd;
    sword[fds_pkg::ST_UVLO] = st_q.uvlo;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        fds_pkg::ADDR_CTRL: st_d.dat = cword;
        fds_pkg::ADDR_STATUS: st_d.dat = sword;
        default: st_d.dat = fds_pkg::DATA_ZERO;
      endcase
    end
    if (wr && (wb_adr_i == fds_pkg::ADDR_CTRL)) begin
      cword = (cword & ~wmask) | (wb_dat_i & wmask);
      c.mode = cword[fds_pkg::CTRL_MODE_LSB +: 2];
      c.vme = cword[fds_pkg::CTRL_VME];
      c.thermistor_sense_enable = cword[fds_pkg::CTRL_THERMISTOR_SENSE_ENABLE];
      c.pg_type = cword[fds_pkg::CTRL_PGTYPE];
      c.hc = cword[fds_pkg::CTRL_HC];
      c.leds = cword[fds_pkg::CTRL_LED_LSB +: 3];
      c.indicator_level = cword[fds_pkg::CTRL_INDICATOR_LEVEL_LSB +: 4];
    end

    // current regulation is suspended by LED overheat or thermal trip
    if (led_hot || (tsd_next && cm_mode)) begin
      c.mode = fds_pkg::MODE_OFF;
    end
    st_d.ctrl = c;

    // sticky level: read clears it, a new event in the same cycle wins
    if (rd_status) begin
      st_d.tj_sticky = fds_pkg::TJ_COOL;
      st_d.overheat = 1'b0;
    end
    if (led_hot || sense_i.tj_over) begin
      st_d.tj_sticky = fds_pkg::TJ_HOT;
    end
    if (led_hot) begin
      st_d.overheat = 1'b1;
    end
    st_d.tj_live = shdn ? fds_pkg::TJ_COOL : sense_i.tj_level;
    st_d.warn = ts_active && sense_i.ts_warn;
    st_d.uvlo = !sense_i.vbat_ok;
    st_d.shdn = shdn;

    // power good: window only, with voltage regulation up and not recycling
    st_d.pg = vm_active && !tsd_next && sense_i.in_window
              && !sense_i.recycling;
    if (shdn) begin
      st_d.pg_out = 1'b0;
      st_d.pg_oe = !c.pg_type;
    end else if (!c.pg_type) begin
      st_d.pg_out = st_d.pg;
      st_d.pg_oe = 1'b1;
    end else begin
      st_d.pg_out = 1'b0;
      st_d.pg_oe = st_d.pg;
    end

    // power stage
    st_d.pwr.switch_en = !shdn && !tsd_next && sense_i.vbat_ok;
    st_d.pwr.rectifier_en = st_d.pwr.switch_en;
    st_d.pwr.led_sink_en = (regulating && !tsd_next && !led_hot) ? c.leds : 3'h0;
    st_d.pwr.flash_current = (c.mode == fds_pkg::MODE_FLASH) && !(blank && !c.hc);
    st_d.pwr.ilim_reduced = c.hc && blank;
    // timer keyed on the software mode, thermal trip and LED overheat, not the pins, so blanking leaves it running
    st_d.pwr.safety_timer_en = cm_mode && !tsd_next && !led_hot;
    st_d.pwr.precharge_bias = shdn && c.hc;
    st_d.pwr.load_disconnect = shdn && !c.hc;
    st_d.pwr.discharge = shdn && !c.hc;
    st_d.pwr.balance_en = c.hc;
    st_d.pwr.ts_bias_en = ts_active;

    // hardware disable: registers to defaults, straight into shutdown
    if (!hwd_n) begin
      st_d.ctrl = ctrl_reset();
      st_d.overheat = 1'b0;
      st_d.tj_sticky = fds_pkg::TJ_COOL;
      st_d.tj_live = fds_pkg::TJ_COOL;
      st_d.warn = 1'b0;
      st_d.pg = 1'b0;
      st_d.shdn = 1'b1;
      st_d.pg_out = 1'b0;
      st_d.pg_oe = 1'b1;
      st_d.pwr = '0;
      st_d.pwr.load_disconnect = 1'b1;
      st_d.pwr.discharge = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.ctrl.leds <= fds_pkg::LED_RESET;
      st_q.hwd_sync <= 2'h3;
      st_q.shdn <= 1'b1;
      st_q.pg_oe <= 1'b1;
      st_q.pwr.load_disconnect <= 1'b1;
      st_q.pwr.discharge <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o = st_q.dat;
  assign wb_ack_o = st_q.ack;
  assign power_good_pin_o = st_q.pg_out;
  assign power_good_pin_oe_o = st_q.pg_oe;
  assign power_o = st_q.pwr;
  assign shutdown_o = st_q.shdn;
endmodule

// [verification/fds_host_model.sv]
// Purpose: camera engine side driving the supervision control pins
// Assumes: bench requests pin changes through cmd_i
// Notes: pins change only just after a rising edge
`timescale 1ns/1ps
module fds_host_model (
  input wire logic clk_i,
  input wire logic [2:0] cmd_i,
  output logic hardware_disable_n_o = 1'b1,
  output logic torch_hw_enable_o = 1'b0,
  output logic flash_blank_input_o = 1'b0
);
  // disable stays high unless the bench asks for a reset
  always @(posedge clk_i) begin
    hardware_disable_n_o <= !cmd_i[2];
    torch_hw_enable_o <= cmd_i[1];
    flash_blank_input_o <= cmd_i[0];
  end
endmodule

// [verification/fds_supervisor_assertions.sv]
// Purpose: port level checks of the supervision block
// Assumes: one clock, synchronous reset
// Notes: sense effects land one edge later, pins three
`timescale 1ns/1ps
module fds_supervisor_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic hardware_disable_n_i,
  input wire fds_pkg::fds_sense_s sense_i,
  input wire logic power_good_pin_o,
  input wire logic power_good_pin_oe_o,
  input wire fds_pkg::fds_power_s power_o,
  input wire logic shutdown_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack after request");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_pg_shdn; shutdown_o [*2] |-> !power_good_pin_o; endproperty
  a_pg_shdn: assert property (p_pg_shdn) else $error("pg pin high in shutdown");
  property p_pg_win; !sense_i.in_window |=> !(power_good_pin_oe_o && power_good_pin_o); endproperty
  a_pg_win: assert property (p_pg_win) else $error("pg high outside window");
  property p_pg_rc; sense_i.recycling |=> !(power_good_pin_oe_o && power_good_pin_o); endproperty
  a_pg_rc: assert property (p_pg_rc) else $error("pg high while recycling");
  property p_uvlo; !sense_i.vbat_ok |=> !power_o.switch_en && !power_o.rectifier_en; endproperty
  a_uvlo: assert property (p_uvlo) else $error("switch on at low battery");
  property p_tsd; sense_i.tj_over |=> power_o.led_sink_en == 3'h0 && !power_o.switch_en; endproperty
  a_tsd: assert property (p_tsd) else $error("stage on when overheated");
  property p_off_dd; (shutdown_o && !power_o.balance_en) [*2] |-> power_o.load_disconnect && power_o.discharge; endproperty
  a_off_dd: assert property (p_off_dd) else $error("shutdown without discharge");
  property p_off_hc; (shutdown_o && power_o.balance_en) [*2] |-> power_o.precharge_bias; endproperty
  a_off_hc: assert property (p_off_hc) else $error("shutdown without bias");
  property p_hwd; !hardware_disable_n_i [*4] |=> shutdown_o; endproperty
  a_hwd: assert property (p_hwd) else $error("no shutdown on disable");
endmodule
bind fds_supervisor fds_supervisor_assertions fds_supervisor_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hardware_disable_n_i(hardware_disable_n_i),
  .sense_i(sense_i), .power_good_pin_o(power_good_pin_o), .power_good_pin_oe_o(power_good_pin_oe_o),
  .power_o(power_o), .shutdown_o(shutdown_o));

// [verification/fds_supervisor_tb.sv]
// Purpose: self-checking bench for the supervision block
// Assumes: ack follows each request, pins via host model
// Notes: six edge waits cover model plus synchroniser
`timescale 1ns/1ps
module fds_supervisor_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pg, pg_oe, shdn, hwd_n, torch, blank;
  logic [3:0] sel = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [2:0] cmd = 3'h0;
  fds_pkg::fds_sense_s sense = 9'h003;
  fds_pkg::fds_power_s pwr;
  int mismatches = 0;
  int checks = 0;
  always #20 clk_i = ~clk_i;
  fds_host_model fds_host_model_i (.clk_i(clk_i), .cmd_i(cmd), .hardware_disable_n_o(hwd_n),
    .torch_hw_enable_o(torch), .flash_blank_input_o(blank));
  fds_supervisor fds_supervisor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .hardware_disable_n_i(hwd_n), .torch_hw_enable_i(torch), .flash_blank_input_i(blank), .sense_i(sense),
    .power_good_pin_o(pg), .power_good_pin_oe_o(pg_oe), .power_o(pwr), .shutdown_o(shdn));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // no cycle limit of its own: a missing ack is caught by the watchdog
  task automatic wb(input logic we_v, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= we_v;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] d);
    wb(1'h1, 8'h00, d);
    w(2);
  endtask
  task automatic rr(input logic [7:0] a);
    wb(1'h0, a, 32'h0);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    w(2000);
    mismatches++;
    finish_test();
  end
  initial begin
    w(5);
    rst_i <= 1'b0;
    rr(8'h00);
    chk("ctrl", rd, 32'h1c0);
    chk("pg pins", {pg_oe, pg}, 2'h2);
    wr(32'h1d0);
    chk("pg oe", pg_oe, 1'h0);
    chk("discharge", pwr.discharge, 1'h1);
    chk("disconnect", pwr.load_disconnect, 1'h1);
    chk("balance off", pwr.balance_en, 1'h0);
    rr(8'h08);
    chk("unmapped", rd, 32'h0);
    sense.in_window <= 1'b1;
    wr(32'h1d3);
    chk("od pins", {pg_oe, pg}, 2'h2);
    wr(32'h1c3);
    chk("pp pins", {pg_oe, pg}, 2'h3);
    chk("ts bias", pwr.ts_bias_en, 1'h0);
    rr(8'h04);
    chk("pg flag", rd[0], 1'h1);
    sense.recycling <= 1'b1;
    w(2);
    chk("pg recycle", pg, 1'h0);
    sense.recycling <= 1'b0;
    sense.vbat_ok <= 1'b0;
    wr(32'h1cb);
    chk("ts bias", pwr.ts_bias_en, 1'h1);
    chk("switch", pwr.switch_en, 1'h0);
    // thermal trip with the cool comparator low: the latch must hold
    sense.vbat_ok <= 1'b1;
    sense.tj_over <= 1'b1;
    sense.tj_cool <= 1'b0;
    w(2);
    chk("tsd switch", pwr.switch_en, 1'h0);
    sense.tj_over <= 1'b0;
    w(2);
    chk("tsd hold", pwr.switch_en, 1'h0);
    sense.tj_cool <= 1'b1;
    w(2);
    chk("vm resume", pwr.switch_en, 1'h1);
    wr(32'h1c4);
    chk("shutdown", shdn, 1'h0);
    chk("pg vme", pg, 1'h1);
    wr(32'h1c0);
    chk("pg off", pg, 1'h0);
    wr(32'h1c1);
    chk("pg off", pg, 1'h0);
    sense.ts_warn <= 1'b1;
    rr(8'h04);
    chk("warm", rd[1], 1'h1);
    chk("tj sticky", rd[4:3], 2'h3);
    sense.tj_level <= 2'h2;
    rr(8'h04);
    chk("tj live", rd[4:3], 2'h2);
    rr(8'h00);
    chk("mode", rd[1:0], 2'h1);
    sense.ts_warn <= 1'b0;
    sense.ts_hot <= 1'b1;
    w(2);
    sense.ts_hot <= 1'b0;
    rr(8'h04);
    chk("overheat", rd[2], 1'h1);
    chk("tj hot", rd[4:3], 2'h3);
    rr(8'h04);
    chk("overheat clr", rd[2], 1'h0);
    chk("tj clr", rd[4:3], 2'h0);
    rr(8'h00);
    chk("mode", rd[1:0], 2'h0);
    chk("shutdown", shdn, 1'h1);
    cmd <= 3'h2;
    w(3);
    chk("sinks sync", pwr.led_sink_en, 3'h0);
    w(3);
    chk("sinks", pwr.led_sink_en, 3'h7);
    chk("timer", pwr.safety_timer_en, 1'h0);
    chk("torch up", shdn, 1'h0);
    wr(32'h3c0);
    chk("sinks", pwr.led_sink_en, 3'h0);
    cmd <= 3'h0;
    wr(32'h1c2);
    chk("flash", pwr.flash_current, 1'h1);
    chk("timer", pwr.safety_timer_en, 1'h1);
    cmd <= 3'h1;
    w(6);
    chk("flash", pwr.flash_current, 1'h0);
    chk("timer blank", pwr.safety_timer_en, 1'h1);
    wr(32'h1e2);
    w(4);
    chk("ilim", pwr.ilim_reduced, 1'h1);
    sense.tj_over <= 1'b1;
    w(2);
    sense.tj_over <= 1'b0;
    rr(8'h04);
    chk("tj sticky", rd[4:3], 2'h3);
    rr(8'h00);
    chk("cm held", rd[1:0], 2'h0);
    cmd <= 3'h0;
    wr(32'h1e0);
    chk("bias", pwr.precharge_bias, 1'h1);
    chk("balance on", pwr.balance_en, 1'h1);
    wr(32'h1e3);
    cmd <= 3'h4;
    w(6);
    rr(8'h00);
    chk("ctrl", rd, 32'h1c0);
    chk("shutdown", shdn, 1'h1);
    chk("bias off", pwr.precharge_bias, 1'h0);
    cmd <= 3'h0;
    w(6);
    finish_test();
  end
endmodule
